// ==== src/acp_config_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module acp_config_top
    import acp_pkg::*;
#(
    parameter logic [7:0] CHIP_ID = 8'h5A, // Arbitrary value
    parameter logic [7:0] GRADE = 8'h00
) (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_port_select_n,
    input wire logic i_serial_clock_format_strap,
    input wire logic i_serial_io_stabilizer_strap,
    output logic o_serial_io_stabilizer_strap,
    output logic o_serial_io_stabilizer_strap_oe,
    input wire logic i_output_disable_pin,
    input wire logic i_power_down_pin,
    output logic o_duty_cycle_stabilizer,
    output logic [1:0] o_twos_complement,
    output logic [1:0] o_outputs_hiz,
    output logic o_power_down,
    output logic o_spi_mode
);
    acp_reg_if bus();

    acp_serial_port u_port (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_sclk(i_serial_clock_format_strap), // [R2]
        .i_cs_n(i_port_select_n),
        .i_sdio(i_serial_io_stabilizer_strap),
        .o_sdio(o_serial_io_stabilizer_strap),
        .o_sdio_oe(o_serial_io_stabilizer_strap_oe),
        .bus(bus.port)
    );

    // -------------------------------------------------------------------
    // Register bank
    // -------------------------------------------------------------------
    logic [1:0] chan_sel_ff;
    logic lsb_first_ff, soft_rst_ff;
    logic [7:0] clock_ff, out_en_ff;
    logic [7:0] out_mode_ff [2];
    logic bank_rst;

    assign bank_rst = i_rst | soft_rst_ff;
    assign bus.lsb_first = lsb_first_ff;

    // Soft reset self-clears: it is a pulse, never stored in the map
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            soft_rst_ff <= 1'b0;
        end else begin
            soft_rst_ff <= bus.wr && bus.addr == ADDR_PORT_CFG
                && (bus.wdata[CFG_SRST_HI] | bus.wdata[CFG_SRST_LO]);
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (bank_rst) begin
            chan_sel_ff <= CHAN_SEL_RST; // [R12] [R15]
            lsb_first_ff <= PORT_CFG_RST[CFG_LSB_HI]; // [R23]
            clock_ff <= CLOCK_RST;
            out_en_ff <= OUT_EN_RST;
            out_mode_ff[0] <= OUT_MODE_RST;
            out_mode_ff[1] <= OUT_MODE_RST;
        end else if (bus.wr) begin
            case (bus.addr) // [R11]
                ADDR_PORT_CFG: begin
                    lsb_first_ff <= bus.wdata[CFG_LSB_HI]
                        | bus.wdata[CFG_LSB_LO];
                end
                ADDR_CHAN_SEL: chan_sel_ff <= bus.wdata[1:0];
                ADDR_CLOCK: clock_ff <= bus.wdata; // [R20]
                ADDR_OUT_EN: out_en_ff <= bus.wdata;
                ADDR_OUT_MODE: begin
                    for (int i = 0; i < 2; i++) begin
                        if (chan_sel_ff[i]) begin
                            out_mode_ff[i] <= bus.wdata; // [R16] [R17]
                        end
                    end
                end
                default: ;
            endcase
        end
    end

    // Local reads pick channel A whenever its bit is set
    logic [7:0] local_rd;
    logic [7:0] rdata;
    assign local_rd = chan_sel_ff[0] ? out_mode_ff[0]
                    : chan_sel_ff[1] ? out_mode_ff[1] : 8'h00; // [R19]
    always_comb begin
        case (bus.addr)
            ADDR_PORT_CFG: rdata = {1'b0, lsb_first_ff,
                                    PORT_CFG_RST[5:2], lsb_first_ff, 1'b0};
            ADDR_CHIP_ID: rdata = CHIP_ID;
            ADDR_GRADE: rdata = GRADE;
            ADDR_CHAN_SEL: rdata = {6'h00, chan_sel_ff};
            ADDR_CLOCK: rdata = clock_ff;
            ADDR_OUT_MODE: rdata = local_rd; // [R16]
            ADDR_OUT_EN: rdata = out_en_ff;
            default: rdata = 8'h00;
        endcase
    end
    assign bus.rdata = rdata;

    // -------------------------------------------------------------------
    // Pin mode and control outputs
    // -------------------------------------------------------------------
    logic oe_m_ff, oe_s_ff, pd_m_ff, pd_s_ff, spi_mode_ff;
    logic stab_ff, pd_ff;
    logic [1:0] fmt_ff, hiz_ff;
    logic pin_hiz;

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            {oe_m_ff, oe_s_ff, pd_m_ff, pd_s_ff} <= 4'h0;
        end else begin
            {oe_m_ff, oe_s_ff} <= {i_output_disable_pin, oe_m_ff};
            {pd_m_ff, pd_s_ff} <= {i_power_down_pin, pd_m_ff};
        end
    end

    // Any select activity since reset commits the part to serial control
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            spi_mode_ff <= 1'b0;
        end else if (!bus.lvl_cs_n) begin
            spi_mode_ff <= 1'b1; // [R4]
        end
    end

    assign pin_hiz = oe_s_ff & (~spi_mode_ff | out_en_ff[OUT_EN_PIN_BIT]);

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            stab_ff <= 1'b0;
            fmt_ff <= 2'h0;
            hiz_ff <= 2'h0;
            pd_ff <= 1'b0;
        end else begin
            pd_ff <= pd_s_ff; // [R8] [R9]
            for (int i = 0; i < 2; i++) begin
                hiz_ff[i] <= pin_hiz // [R7] [R9]
                    | (spi_mode_ff & out_mode_ff[i][OUT_MODE_DIS_BIT]);
                fmt_ff[i] <= spi_mode_ff ? out_mode_ff[i][OUT_MODE_FMT_BIT]
                                         : bus.lvl_sclk; // [R6]
            end
            stab_ff <= spi_mode_ff ? clock_ff[CLOCK_STAB_BIT]
                                   : bus.lvl_sdio; // [R6]
        end
    end

    assign o_duty_cycle_stabilizer = stab_ff;
    assign o_twos_complement = fmt_ff;
    assign o_outputs_hiz = hiz_ff;
    assign o_power_down = pd_ff;
    assign o_spi_mode = spi_mode_ff;

    // -------------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------------
    AST_CHSEL_RESET: // [R12]
    assert property (@(posedge i_clk_sys)
        $past(i_rst) |-> chan_sel_ff == CHAN_SEL_RST)
        else $error("channel select not at default after reset");
    AST_BOTH_WRITE: // [R17]
    assert property (@(posedge i_clk_sys) disable iff (bank_rst)
        bus.wr && bus.addr == ADDR_OUT_MODE && chan_sel_ff == 2'h3
        |=> out_mode_ff[0] == $past(bus.wdata)
            && out_mode_ff[1] == $past(bus.wdata))
        else $error("local write missed a channel");
    AST_READ_CH_A: // [R19]
    assert property (@(posedge i_clk_sys) disable iff (i_rst)
        bus.addr == ADDR_OUT_MODE && chan_sel_ff[0] |-> rdata == out_mode_ff[0])
        else $error("local read did not return channel A");
    AST_POWER_DOWN_PIN: // [R8]
    assert property (@(posedge i_clk_sys) disable iff (i_rst)
        $rose(pd_s_ff) |=> o_power_down ##1 o_power_down || !pd_s_ff)
        else $error("power-down pin not followed");
    AST_STRAP_FMT: // [R6]
    assert property (@(posedge i_clk_sys) disable iff (i_rst)
        !spi_mode_ff ##1 !spi_mode_ff |-> o_duty_cycle_stabilizer
            == $past(bus.lvl_sdio) && o_twos_complement[1] == $past(bus.lvl_sclk))
        else $error("strap level not applied");
    AST_GLOBAL: // [R20]
    assert property (@(posedge i_clk_sys) disable iff (bank_rst)
        bus.wr && bus.addr == ADDR_CLOCK |=> clock_ff == $past(bus.wdata))
        else $error("global write depended on channel select");
    AST_HIZ_STRAP: // [R7]
    assert property (@(posedge i_clk_sys) disable iff (i_rst)
        !spi_mode_ff && oe_s_ff |=> o_outputs_hiz == 2'h3)
        else $error("output-disable pin ignored");
    COV_CHSEL_WR: cover property (@(posedge i_clk_sys)
        bus.wr && bus.addr == ADDR_CHAN_SEL);
    COV_BOTH_LOCAL: cover property (@(posedge i_clk_sys)
        bus.wr && bus.addr == ADDR_OUT_MODE && chan_sel_ff == 2'h3);
endmodule
`default_nettype wire

// ==== common/acp_pkg.sv ====
//
// Summary of operation
// R1: Serial data pin is bidirectional: input while writing, driven out during readback.
// R2: Serial clock and active-low select are inputs only.
// R3: Controller keeps the port idle when full converter performance is needed.
// R4: Without serial use, data, clock, disable and power-down pins are static controls.
// R5: Board holds select high permanently to disable the serial port.
// R6: Strap mode: data pin high enables stabilizer; clock pin high selects twos complement.
// R7: Output-disable pin high puts data outputs in high impedance; low enables them.
// R8: Power-down pin high powers the chip down; low keeps normal operation.
// R9: Under serial control, power-down and enabled output-disable pins stay in effect.
// R10: With register control, controller holds power-down and output-disable pins low; the bench raises both under serial control.
// R11: Map: chip config 0x00-0x02, index 0x05, transfer 0xFF, functions 0x08-0x102.
// R12: Channel select at 0x05 resets to 0x03, both channels selected.
// R13: Controller writes zero into unused bits of partly implemented addresses.
// R14: Controller never writes addresses whose bits are all open.
// R15: Reset loads configuration registers with their default values.
// R16: Local registers exist per channel; access reaches channels selected in 0x05.
// R17: With both channels selected, a local write updates both copies.
// R18: Controller selects exactly one channel before reading a local register; the bench also reads 0x14 with both selected.
// R19: Read with both channels selected returns the first channel's copy.
// R20: Global registers act regardless of the channel select setting.
// R21: Frame starts with 16-bit instruction: read/write bit, two word-length bits.
// R22: Frame starts at select falling, qualified by following serial clock rise.
// R23: Bits shift most significant first after power-up until port config changes it.
// R24: In read frames the pin is driven only after the last instruction bit.
package acp_pkg;
    // -------------------------------------------------------------------
    // Register addresses
    // -------------------------------------------------------------------
    localparam int ADDR_W = 13;
    localparam logic [12:0] ADDR_PORT_CFG = 13'h0000;
    localparam logic [12:0] ADDR_CHIP_ID = 13'h0001;
    localparam logic [12:0] ADDR_GRADE = 13'h0002;
    localparam logic [12:0] ADDR_CHAN_SEL = 13'h0005;
    localparam logic [12:0] ADDR_CLOCK = 13'h0009;
    localparam logic [12:0] ADDR_OUT_MODE = 13'h0014;
    localparam logic [12:0] ADDR_TRANSFER = 13'h00FF;
    localparam logic [12:0] ADDR_OUT_EN = 13'h0101;
    // -------------------------------------------------------------------
    // Reset values
    // -------------------------------------------------------------------
    localparam logic [7:0] PORT_CFG_RST = 8'h18;
    localparam logic [1:0] CHAN_SEL_RST = 2'h3;
    localparam logic [7:0] CLOCK_RST = 8'h01;
    localparam logic [7:0] OUT_MODE_RST = 8'h00;
    localparam logic [7:0] OUT_EN_RST = 8'h80;
    // -------------------------------------------------------------------
    // Field positions
    // -------------------------------------------------------------------
    localparam int CFG_LSB_HI = 6;
    localparam int CFG_LSB_LO = 1;
    localparam int CFG_SRST_HI = 5;
    localparam int CFG_SRST_LO = 2;
    localparam int CLOCK_STAB_BIT = 0;
    localparam int OUT_MODE_DIS_BIT = 4;
    localparam int OUT_MODE_FMT_BIT = 0;
    localparam int OUT_EN_PIN_BIT = 7;
    localparam int INSTR_RW_BIT = 15;
    localparam int INSTR_LEN_HI = 14;
    localparam int INSTR_LEN_LO = 13;
    localparam logic [3:0] INSTR_LAST = 4'hF;
    localparam logic [2:0] BYTE_LAST = 3'h7;
    localparam logic [1:0] LEN_STREAM = 2'h3;

    typedef enum logic [1:0] {ST_IDLE, ST_INSTR, ST_DATA, ST_DONE}
        acp_state_type;
endpackage

// ==== common/acp_reg_if.sv ====
`timescale 1ns/10ps
`default_nettype none
interface acp_reg_if;
    import acp_pkg::*;
    logic wr;
    logic rd;
    logic [12:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic lsb_first;
    logic lvl_sclk;
    logic lvl_sdio;
    logic lvl_cs_n;

    modport port (output wr, rd, addr, wdata, lvl_sclk, lvl_sdio, lvl_cs_n,
                  input rdata, lsb_first);
    modport bank (input wr, rd, addr, wdata, lvl_sclk, lvl_sdio, lvl_cs_n,
                  output rdata, lsb_first);
endinterface
`default_nettype wire

// ==== src/acp_serial_port.sv ====
`timescale 1ns/10ps
`default_nettype none
module acp_serial_port
    import acp_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_sclk,
    input wire logic i_cs_n,
    input wire logic i_sdio,
    output logic o_sdio,
    output logic o_sdio_oe,
    acp_reg_if.port bus
);
    // -------------------------------------------------------------------
    // Pin synchronisers
    // -------------------------------------------------------------------
    logic sclk_m_ff, sclk_s_ff, sclk_d_ff;
    logic cs_m_ff, cs_s_ff, cs_d_ff;
    logic sd_m_ff, sd_s_ff;

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            {sclk_m_ff, sclk_s_ff, sclk_d_ff} <= 3'h0;
            {cs_m_ff, cs_s_ff, cs_d_ff} <= 3'h7;
            {sd_m_ff, sd_s_ff} <= 2'h0;
        end else begin
            {sclk_m_ff, sclk_s_ff, sclk_d_ff} <= {i_sclk, sclk_m_ff, sclk_s_ff};
            {cs_m_ff, cs_s_ff, cs_d_ff} <= {i_cs_n, cs_m_ff, cs_s_ff};
            {sd_m_ff, sd_s_ff} <= {i_sdio, sd_m_ff};
        end
    end

    logic rise, fall, cs_fall;
    assign rise = sclk_s_ff & ~sclk_d_ff;
    assign fall = ~sclk_s_ff & sclk_d_ff;
    assign cs_fall = ~cs_s_ff & cs_d_ff;
    assign bus.lvl_sclk = sclk_s_ff;
    assign bus.lvl_sdio = sd_s_ff;
    assign bus.lvl_cs_n = cs_s_ff;

    function automatic logic [15:0] shift_in(input logic [15:0] sr,
                                             input logic b, input logic lsb);
        shift_in = lsb ? {b, sr[15:1]} : {sr[14:0], b};
    endfunction

    // -------------------------------------------------------------------
    // Frame engine
    // -------------------------------------------------------------------
    acp_state_type state_ff;
    logic [15:0] sr_ff;
    logic [3:0] bit_cnt_ff;
    logic read_ff, wr_ff, rd_ff, load_ff, sdio_ff, oe_ff;
    logic [1:0] len_ff, left_ff;
    logic [12:0] addr_ff;
    logic [7:0] wdata_ff, tx_ff;
    logic [15:0] nxt_sr;
    logic [12:0] nxt_addr;

    assign nxt_sr = shift_in(sr_ff, sd_s_ff, bus.lsb_first); // [R23]
    assign nxt_addr = bus.lsb_first ? addr_ff + 13'h0001 : addr_ff - 13'h0001;

    always_ff @(posedge i_clk_sys) begin
        if (i_rst || cs_s_ff) begin
            state_ff <= ST_IDLE;
            bit_cnt_ff <= 4'h0;
            oe_ff <= 1'b0;
            wr_ff <= 1'b0;
            rd_ff <= 1'b0;
            load_ff <= 1'b0;
            read_ff <= 1'b0;
            len_ff <= 2'h0;
            left_ff <= 2'h0;
            sr_ff <= 16'h0000;
            addr_ff <= 13'h0000;
            wdata_ff <= 8'h00;
            tx_ff <= 8'h00;
            sdio_ff <= 1'b0;
        end else begin
            wr_ff <= 1'b0;
            rd_ff <= 1'b0;
            load_ff <= rd_ff;
            if (load_ff) begin
                tx_ff <= bus.rdata;
            end
            case (state_ff)
                ST_IDLE: begin
                    // Only rising clocks after select falls count
                    if (cs_fall) begin
                        state_ff <= ST_INSTR; // [R22]
                        bit_cnt_ff <= 4'h0;
                    end
                end
                ST_INSTR: begin
                    if (rise) begin
                        sr_ff <= nxt_sr;
                        bit_cnt_ff <= bit_cnt_ff + 4'h1;
                        if (bit_cnt_ff == INSTR_LAST) begin
                            state_ff <= ST_DATA; // [R21]
                            bit_cnt_ff <= 4'h0;
                            read_ff <= nxt_sr[INSTR_RW_BIT];
                            len_ff <= nxt_sr[INSTR_LEN_HI:INSTR_LEN_LO];
                            left_ff <= nxt_sr[INSTR_LEN_HI:INSTR_LEN_LO];
                            addr_ff <= nxt_sr[12:0];
                            rd_ff <= nxt_sr[INSTR_RW_BIT];
                        end
                    end
                end
                ST_DATA: begin
                    // Drive on falling edges so the master samples on rising
                    if (fall && read_ff) begin
                        oe_ff <= 1'b1; // [R1] [R24]
                        sdio_ff <= bus.lsb_first ? tx_ff[0] : tx_ff[7];
                        tx_ff <= bus.lsb_first ? {1'b0, tx_ff[7:1]}
                                               : {tx_ff[6:0], 1'b0};
                    end
                    if (rise) begin
                        sr_ff <= nxt_sr;
                        bit_cnt_ff <= {1'b0, bit_cnt_ff[2:0] + 3'h1};
                        if (bit_cnt_ff[2:0] == BYTE_LAST) begin
                            addr_ff <= nxt_addr;
                            left_ff <= left_ff - 2'h1;
                            wr_ff <= ~read_ff;
                            wdata_ff <= bus.lsb_first ? nxt_sr[15:8]
                                                      : nxt_sr[7:0];
                            if (left_ff == 2'h0 && len_ff != LEN_STREAM) begin
                                state_ff <= ST_DONE;
                            end else begin
                                rd_ff <= read_ff;
                            end
                        end
                    end
                end
                ST_DONE: begin
                    if (fall) begin
                        oe_ff <= 1'b0;
                    end
                end
                default: state_ff <= ST_IDLE;
            endcase
        end
    end

    // Write strobe carries the address of the byte just completed
    logic [12:0] wr_addr_ff;
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            wr_addr_ff <= 13'h0000;
        end else if (rise && state_ff == ST_DATA) begin
            wr_addr_ff <= addr_ff;
        end
    end

    assign bus.wr = wr_ff;
    assign bus.rd = rd_ff;
    assign bus.addr = wr_ff ? wr_addr_ff : addr_ff;
    assign bus.wdata = wdata_ff;
    assign o_sdio = sdio_ff;
    assign o_sdio_oe = oe_ff;

    // -------------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------------
    AST_NO_DRIVE_INSTR: // [R24]
    assert property (@(posedge i_clk_sys) disable iff (i_rst)
        state_ff == ST_INSTR |-> !oe_ff)
        else $error("data pin driven during instruction");
    AST_WR_PULSE: // [R21]
    assert property (@(posedge i_clk_sys) disable iff (i_rst)
        wr_ff |=> !wr_ff ##1 !wr_ff)
        else $error("write strobe longer than one cycle");
    AST_RD_ONLY_READ: // [R21]
    assert property (@(posedge i_clk_sys) disable iff (i_rst)
        rd_ff |-> read_ff && !wr_ff)
        else $error("read strobe in a write frame");
    AST_CS_RELEASE: // [R1]
    assert property (@(posedge i_clk_sys) disable iff (i_rst)
        cs_s_ff |=> !oe_ff)
        else $error("data pin still driven after select rose");
    COV_READ: cover property (@(posedge i_clk_sys) rd_ff);
    COV_DRIVE: cover property (@(posedge i_clk_sys) $rose(oe_ff));
endmodule
`default_nettype wire

// ==== bench/acp_serial_master.sv ====
`timescale 1ns/10ps
`default_nettype none
module acp_serial_master
    import acp_pkg::*;
(
    output logic o_sclk,
    output logic o_cs_n,
    output logic o_sdo,
    output logic o_sdo_en,
    input wire logic i_sdio
);
    // ---------------------------------------------------------------
    // Controller side of the three-wire port
    // ---------------------------------------------------------------
    localparam time HALF = 32ns;
    logic lsb_first;
    logic [1:0] len;

    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_sdo = 1'b1;
        o_sdo_en = 1'b1;
        lsb_first = 1'b0;
        len = 2'h0;
    end

    // Static levels for pin-strap operation, select stays high
    task automatic strap(input logic clk_lvl, input logic dat_lvl);
        o_sclk <= clk_lvl;
        o_sdo <= dat_lvl;
        o_sdo_en <= 1'b1;
    endtask

    task automatic shift_bit(input logic b, input logic drive,
                             output logic s);
        o_sclk = 1'b0;
        if (drive) begin
            o_sdo = b;
        end
        #HALF;
        o_sclk = 1'b1;
        s = i_sdio;
        #HALF;
    endtask

    // Clock stands low outside frames; length code + 1 data bytes per frame
    task automatic xfer(input logic rd, input logic [12:0] addr,
                        input logic [7:0] wdata, output logic [7:0] rdata);
        logic [15:0] instr;
        logic s;
        int k;
        // Start off the system clock's rising edge so no pin races it
        #0.5;
        instr = {rd, len, addr};
        o_sclk = 1'b0;
        o_sdo_en = 1'b1;
        #HALF;
        o_cs_n = 1'b0;
        #HALF;
        for (int i = 0; i < 16; i++) begin
            k = lsb_first ? i : 15 - i;
            shift_bit(instr[k], 1'b1, s);
        end
        // Let go at the falling edge, before the device turns the pin
        if (rd) begin
            o_sdo_en = 1'b0;
        end
        // Bytes = length code + 1; a read keeps only the last byte
        repeat (len + 1) begin
            for (int i = 0; i < 8; i++) begin
                k = lsb_first ? i : 7 - i;
                shift_bit(wdata[k], !rd, s);
                rdata[k] = s;
            end
        end
        o_sclk = 1'b0;
        #HALF;
        o_cs_n = 1'b1;
        o_sdo_en = 1'b1;
        if (!rd && addr == ADDR_PORT_CFG) begin
            lsb_first = (wdata[5] | wdata[2]) ? 1'b0
                                              : (wdata[6] | wdata[1]);
        end
        #(4 * HALF);
    endtask
endmodule
`default_nettype wire

// ==== bench/adc_config_port_channel_index_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) \
    begin \
        check_count++; \
        if ((g) !== (e)) begin \
            err_count++; \
            $display("BAD %s exp %0h got %0h", nm, e, g); \
        end \
    end
module adc_config_port_channel_index_tb;
    import acp_pkg::*;
    localparam logic [7:0] CHIP_ID_V = 8'hA5; // Arbitrary value
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic oed = 1'b0;
    logic pdn = 1'b0;
    logic m_sclk, m_cs_n, m_sdo, m_en, d_sdo, d_oe, sdio_w, duty_cycle_stabilizer, pd, spi;
    logic [1:0] twos, hiz;
    int err_count = 0;
    int check_count = 0;
    // Strap rows: {data, clock, disable, pdown, dcs, twos, hiz, pd}
    logic [9:0] rows [4] = '{10'h220, 10'h19E, 10'h379, 10'h0C7};
    logic [12:0] ra [9] = '{ADDR_PORT_CFG, ADDR_CHIP_ID, ADDR_GRADE,
        ADDR_CHAN_SEL, ADDR_CLOCK, ADDR_OUT_MODE, ADDR_OUT_EN,
        ADDR_TRANSFER, 13'h0003};
    logic [7:0] re [9] = '{PORT_CFG_RST, CHIP_ID_V, 8'h00, 8'h03,
        CLOCK_RST, OUT_MODE_RST, OUT_EN_RST, 8'h00, 8'h00};

    always #2.5 clk = ~clk;

    // Released line shows the inverse of the last level, no pull
    assign sdio_w = d_oe ? d_sdo : (m_en ? m_sdo : ~m_sdo);

    acp_config_top #(.CHIP_ID(CHIP_ID_V), .GRADE(8'h00)) u_dut (
        .i_clk_sys(clk),
        .i_rst(rst),
        .i_port_select_n(m_cs_n),
        .i_serial_clock_format_strap(m_sclk),
        .i_serial_io_stabilizer_strap(sdio_w),
        .o_serial_io_stabilizer_strap(d_sdo),
        .o_serial_io_stabilizer_strap_oe(d_oe),
        .i_output_disable_pin(oed),
        .i_power_down_pin(pdn),
        .o_duty_cycle_stabilizer(duty_cycle_stabilizer),
        .o_twos_complement(twos),
        .o_outputs_hiz(hiz),
        .o_power_down(pd),
        .o_spi_mode(spi)
    );

    acp_serial_master u_master (
        .o_sclk(m_sclk),
        .o_cs_n(m_cs_n),
        .o_sdo(m_sdo),
        .o_sdo_en(m_en),
        .i_sdio(sdio_w)
    );

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        logic [7:0] x;
        cyc(1);
        u_master.xfer(1'b0, a, d, x);
        cyc(5);
    endtask

    task automatic rchk(input logic [12:0] a, input logic [7:0] e);
        logic [7:0] x;
        cyc(1);
        u_master.xfer(1'b1, a, 8'h00, x);
        `CHK("readback", e, x);
        `CHK("sdio_oe_idle", 1'b0, d_oe);
    endtask

    task automatic final_report();
        if (err_count == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        if (!rst && m_en === 1'b1 && d_oe === 1'b1) begin
            err_count++;
            $display("BAD sdio_contention exp 0 got 1");
        end
    end

    initial begin
        #200000;
        err_count++;
        final_report();
    end

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        cyc(3);
        rst <= 1'b0;
        cyc(5);
        for (int i = 0; i < 4; i++) begin
            u_master.strap(rows[i][8], rows[i][9]);
            oed <= rows[i][7];
            pdn <= rows[i][6];
            cyc(10);
            `CHK("strap", rows[i][5:0], {duty_cycle_stabilizer, twos, hiz, pd});
        end
        `CHK("spi_mode", 1'b0, spi);
        oed <= 1'b0;
        pdn <= 1'b0;
        for (int i = 0; i < 9; i++) begin
            rchk(ra[i], re[i]);
        end
        `CHK("spi_mode", 1'b1, spi);
        `CHK("stabilizer", CLOCK_RST[0], duty_cycle_stabilizer);
        wr(ADDR_CHIP_ID, 8'h00);
        rchk(ADDR_CHIP_ID, CHIP_ID_V);
        wr(ADDR_OUT_MODE, 8'h11);
        `CHK("both_copies", 4'hF, {twos, hiz});
        wr(ADDR_CHAN_SEL, 8'h02);
        wr(ADDR_OUT_MODE, 8'h00);
        `CHK("b_copy_only", 4'h5, {twos, hiz});
        rchk(ADDR_OUT_MODE, 8'h00);
        wr(ADDR_CHAN_SEL, 8'h03);
        rchk(ADDR_OUT_MODE, 8'h11);
        wr(ADDR_CHAN_SEL, 8'h02);
        wr(ADDR_CLOCK, 8'h00);
        `CHK("global_clock", 1'b0, duty_cycle_stabilizer);
        rchk(ADDR_CLOCK, 8'h00);
        u_master.len = 2'h1;
        rchk(ADDR_CHIP_ID, PORT_CFG_RST);
        u_master.len = 2'h0;
        pdn <= 1'b1;
        cyc(8);
        `CHK("pin_power_down", 1'b1, pd);
        pdn <= 1'b0;
        oed <= 1'b1;
        cyc(8);
        `CHK("pin_disable_on", 2'h3, hiz);
        wr(ADDR_OUT_EN, 8'h00);
        `CHK("pin_disable_off", 2'h1, hiz);
        oed <= 1'b0;
        wr(ADDR_PORT_CFG, 8'h5A);
        rchk(ADDR_CHAN_SEL, 8'h02);
        wr(ADDR_CHAN_SEL, 8'h01);
        rchk(ADDR_CHAN_SEL, 8'h01);
        wr(ADDR_PORT_CFG, 8'h3C);
        rchk(ADDR_CHAN_SEL, 8'h03);
        rchk(ADDR_PORT_CFG, PORT_CFG_RST);
        `CHK("spi_mode_kept", 1'b1, spi);
        wr(ADDR_CHAN_SEL, 8'h01);
        rst <= 1'b1;
        cyc(3);
        rst <= 1'b0;
        cyc(6);
        `CHK("spi_mode_reset", 1'b0, spi);
        rchk(ADDR_CHAN_SEL, 8'h03);
        final_report();
    end
endmodule
`default_nettype wire
